// file: core/bitfield_test_modify_unit.sv
/*
 * Masked bit-field test and modify unit of the 16-bit core.
 * Takes a decoded instruction, reads the operand from the register file
 * or data memory, tests the masked bits into carry, and for the
 * modifying operations writes the result back to where it was read.
 * Assumes register file and memory answer a read one cycle after the
 * request, on the same clock, and that the controller holds off the
 * next command until the unit is ready.
 */
`timescale 1ns/100ps
`include "bitfield_defines.svh"

// Behaviour
// - Test high: carry when masked bits all one
// - Test low: carry when masked bits all zero
// - Invert: carry if all one, invert masked bits
// - Zero: carry if all one, clear masked bits
// - Raise: carry if all zero, set masked bits
// - Sixteen-bit immediate mask selects tested bits
// - Hardware stack register refused as operand
// - Short absolute address from six-bit field
// - Register, short forms: four cycles, two words
// - Pointer, stack forms six/two; long six/three
// - Pointer two plus six-bit unsigned offset
// - Stack pointer minus six-bit unsigned offset
// - Short I/O field selects peripheral region
module bitfield_test_modify_unit #(
  parameter logic [`BF_REG_IDX_W-1:0] HW_STACK_CODE = `BF_HW_STACK_CODE,
  parameter logic [`BF_DATA_W-1:0] IO_BASE = `BF_IO_BASE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command from the program controller
  input wire logic start,
  input wire bitfield_pkg::cmd_t cmd,
  output logic ready_q,
  output logic done_q,
  output logic refused_q,
  output logic [1:0] words_q,
  // Carry flag towards the status register
  output logic carry_q,
  output logic carry_we_q,
  // Address registers
  input wire logic [`BF_DATA_W-1:0] pointer_register_two,
  input wire logic [`BF_DATA_W-1:0] stack_pointer,
  // Register file port
  output logic reg_rd_en_q,
  output logic [`BF_REG_IDX_W-1:0] reg_rd_idx_q,
  input wire logic [`BF_DATA_W-1:0] reg_rd_data,
  output logic reg_wr_en_q,
  output logic [`BF_REG_IDX_W-1:0] reg_wr_idx_q,
  output logic [`BF_DATA_W-1:0] reg_wr_data_q,
  // Data memory port
  output logic mem_rd_en_q,
  output logic mem_wr_en_q,
  output logic [`BF_DATA_W-1:0] mem_addr_q,
  input wire logic [`BF_DATA_W-1:0] mem_rd_data,
  output logic [`BF_DATA_W-1:0] mem_wr_data_q
);

  typedef enum logic [1:0] {st_idle, st_busy} state_t;

  localparam logic [2:0] CYC_SHORT = 3'(`BF_CYCLES_SHORT);
  localparam logic [2:0] CYC_LONG = 3'(`BF_CYCLES_LONG);
  localparam logic [2:0] PH_DATA = 3'd2;

  // Refuse an I/O base whose low bits under the short I/O field are not all zero
  if (IO_BASE[`BF_SHORT_W-1:0] != '0) begin : g_bad_io_base
    $error("IO_BASE must be aligned to the short I/O field");
  end

  state_t state_q;
  state_t state_d;
  bitfield_pkg::cmd_t cmd_q;
  logic [2:0] ph_q;
  logic [2:0] total_q;
  logic [`BF_DATA_W-1:0] operand_q;

  // Decode of the incoming command
  wire logic [`BF_DATA_W-1:0] offset_w = {{(`BF_DATA_W-`BF_SHORT_W){1'b0}}, cmd.short_field};
  wire logic is_reg_w = (cmd.mode == bitfield_pkg::mode_register);
  wire logic refuse_w = is_reg_w && (cmd.reg_idx == HW_STACK_CODE);
  wire logic long_w = (cmd.mode == bitfield_pkg::mode_pointer_offset) ||
                      (cmd.mode == bitfield_pkg::mode_stack_relative) ||
                      (cmd.mode == bitfield_pkg::mode_long_absolute);
  wire logic [2:0] total_w = long_w ? CYC_LONG : CYC_SHORT;
  wire logic [1:0] words_w = (cmd.mode == bitfield_pkg::mode_long_absolute) ?
                             2'(`BF_WORDS_LONG) : 2'(`BF_WORDS_SHORT);
  wire logic last_w = (state_q == st_busy) && (ph_q == total_q);
  // Ready already marks idle and closing cycles; it also keeps the first cycle after reset refusing
  wire logic take_w = start && ready_q;
  wire logic run_w = take_w && !refuse_w;

  // Effective data-memory address per addressing form
  wire logic [`BF_DATA_W-1:0] addr_ptr_w = `BF_DATA_W'(pointer_register_two + offset_w);
  wire logic [`BF_DATA_W-1:0] addr_sp_w = `BF_DATA_W'(stack_pointer - offset_w);
  wire logic [`BF_DATA_W-1:0] addr_abs_w = offset_w;
  wire logic [`BF_DATA_W-1:0] addr_io_w = IO_BASE | offset_w;
  logic [`BF_DATA_W-1:0] addr_w;
  always_comb begin
    case (cmd.mode)
      bitfield_pkg::mode_pointer_offset: addr_w = addr_ptr_w;
      bitfield_pkg::mode_stack_relative: addr_w = addr_sp_w;
      bitfield_pkg::mode_short_absolute: addr_w = addr_abs_w;
      bitfield_pkg::mode_short_io: addr_w = addr_io_w;
      bitfield_pkg::mode_long_absolute: addr_w = cmd.long_addr;
      default: addr_w = `BF_WORD_RESET;
    endcase
  end

  // Masked tests; only bits where the mask is one take part
  wire logic [`BF_DATA_W-1:0] mask_w = cmd_q.immediate_bit_mask;
  wire logic all_one_w = &(operand_q | ~mask_w);
  wire logic all_zero_w = ~|(operand_q & mask_w);
  wire logic modify_w = (cmd_q.op == bitfield_pkg::invert_masked_bits) ||
                        (cmd_q.op == bitfield_pkg::zero_masked_bits) ||
                        (cmd_q.op == bitfield_pkg::raise_masked_bits);

  // Carry and new word per operation
  logic carry_w;
  logic [`BF_DATA_W-1:0] result_w;
  always_comb begin
    case (cmd_q.op)
      bitfield_pkg::test_masked_bits_high: begin
        carry_w = all_one_w;
        result_w = operand_q;
      end
      bitfield_pkg::test_masked_bits_low: begin
        carry_w = all_zero_w;
        result_w = operand_q;
      end
      bitfield_pkg::invert_masked_bits: begin
        carry_w = all_one_w;
        result_w = operand_q ^ mask_w;
      end
      bitfield_pkg::zero_masked_bits: begin
        carry_w = all_one_w;
        result_w = operand_q & ~mask_w;
      end
      bitfield_pkg::raise_masked_bits: begin
        carry_w = all_zero_w;
        result_w = operand_q | mask_w;
      end
      default: begin
        carry_w = carry_q;
        result_w = operand_q;
      end
    endcase
  end

  // Results land on the second-to-last edge so every form ends on time
  wire logic finish_w = (state_q == st_busy) && (ph_q == total_q - 3'd1);
  wire logic capture_w = (state_q == st_busy) && (ph_q == PH_DATA);
  wire logic wb_reg_w = finish_w && modify_w && (cmd_q.mode == bitfield_pkg::mode_register);
  wire logic wb_mem_w = finish_w && modify_w && (cmd_q.mode != bitfield_pkg::mode_register);

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      st_idle: if (run_w) state_d = st_busy;
      st_busy: if (last_w && !run_w) state_d = st_idle;
      default: state_d = st_idle;
    endcase
  end

  // State, phase and latched command
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= st_idle;
      ph_q <= 3'h0;
      total_q <= CYC_SHORT;
      cmd_q <= '0;
    end else begin
      state_q <= state_d;
      ph_q <= run_w ? 3'h1 : (state_q == st_busy ? 3'(ph_q + 3'h1) : 3'h0);
      if (run_w) begin
        total_q <= total_w;
        cmd_q <= cmd;
      end
    end
  end

  // Operand read request, one cycle wide, and its capture
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rd_en_q <= 1'b0;
      reg_rd_idx_q <= '0;
      mem_rd_en_q <= 1'b0;
      mem_addr_q <= `BF_WORD_RESET;
      operand_q <= `BF_WORD_RESET;
    end else begin
      reg_rd_en_q <= run_w && is_reg_w;
      mem_rd_en_q <= run_w && !is_reg_w;
      if (run_w) begin
        reg_rd_idx_q <= cmd.reg_idx;
        mem_addr_q <= addr_w; // Held so write-back reuses the read address
      end
      if (capture_w) operand_q <= (cmd_q.mode == bitfield_pkg::mode_register) ? reg_rd_data : mem_rd_data;
    end
  end

  // Write-back to the location read, only for modifying operations
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_wr_en_q <= 1'b0;
      reg_wr_idx_q <= '0;
      reg_wr_data_q <= `BF_WORD_RESET;
      mem_wr_en_q <= 1'b0;
      mem_wr_data_q <= `BF_WORD_RESET;
    end else begin
      reg_wr_en_q <= wb_reg_w;
      mem_wr_en_q <= wb_mem_w;
      if (wb_reg_w) begin
        reg_wr_idx_q <= cmd_q.reg_idx;
        reg_wr_data_q <= result_w;
      end
      if (wb_mem_w) mem_wr_data_q <= result_w;
    end
  end

  // Carry, completion and refusal reporting
  always_ff @(posedge clk) begin
    if (reset) begin
      carry_q <= `BF_CARRY_RESET;
      carry_we_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
      words_q <= 2'(`BF_WORDS_SHORT);
    end else begin
      carry_we_q <= finish_w;
      if (finish_w) carry_q <= carry_w;
      // A refused command still completes so the controller never hangs
      done_q <= finish_w || (take_w && refuse_w);
      refused_q <= take_w && refuse_w;
      if (take_w) words_q <= words_w;
    end
  end

  // Ready while idle or in the closing cycle of an operation
  always_ff @(posedge clk) begin
    if (reset) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (state_d == st_idle) || (run_w ? (total_w == 3'h1) : ((state_q == st_busy) && (ph_q == total_q - 3'd1)));
    end
  end

endmodule : bitfield_test_modify_unit

// file: include/bitfield_defines.svh
/*
 * Constants of the masked bit-field test and modify unit:
 * field widths, cycle counts, instruction lengths and reset values.
 * Assumes it is included by bare name from packages and core files.
 */
`ifndef BITFIELD_DEFINES_SVH
`define BITFIELD_DEFINES_SVH

// Datapath and field widths
`define BF_DATA_W 16
`define BF_REG_IDX_W 5
`define BF_SHORT_W 6

// Cycles per form, counted from the taking edge to the end
`define BF_CYCLES_SHORT 4
`define BF_CYCLES_LONG 6

// Program words per form
`define BF_WORDS_SHORT 2
`define BF_WORDS_LONG 3

// Register code of the hardware stack in the operand set (arbitrary default)
`define BF_HW_STACK_CODE 5'h1F

// Base of the peripheral I/O region (arbitrary default)
`define BF_IO_BASE 16'hFFC0

// Reset values
`define BF_CARRY_RESET 1'b0
`define BF_WORD_RESET 16'h0000

`endif

// file: include/bitfield_pkg.sv
/*
 * Types of the masked bit-field test and modify unit: operation and
 * addressing enumerations and the command struct.
 * Assumes bitfield_defines.svh is on the include path.
 */
`include "bitfield_defines.svh"

package bitfield_pkg;

  // Five masked bit-field operations
  typedef enum logic [2:0] {
    test_masked_bits_high,
    test_masked_bits_low,
    invert_masked_bits,
    zero_masked_bits,
    raise_masked_bits
  } op_t;

  // Operand addressing forms
  typedef enum logic [2:0] {
    mode_register,
    mode_pointer_offset,
    mode_stack_relative,
    mode_short_absolute,
    mode_short_io,
    mode_long_absolute
  } mode_t;

  // One decoded instruction from the program controller
  typedef struct packed {
    op_t op;
    mode_t mode;
    logic [`BF_DATA_W-1:0] immediate_bit_mask;
    logic [`BF_REG_IDX_W-1:0] reg_idx;
    logic [`BF_SHORT_W-1:0] short_field;
    logic [`BF_DATA_W-1:0] long_addr;
  } cmd_t;

endpackage : bitfield_pkg

// file: verif/bitfield_checker.sv
/* Checker of the bit-field unit: timing, refusal, write-back.
 * Sees only the unit's ports; bound after the module. */
`timescale 1ns/100ps
`include "bitfield_defines.svh"
module bitfield_checker #(
  parameter logic [4:0] HW_STACK_CODE = `BF_HW_STACK_CODE
) (
  // Clock and command
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire bitfield_pkg::cmd_t cmd,
  // Status and ports
  input wire logic ready_q,
  input wire logic done_q,
  input wire logic refused_q,
  input wire logic [1:0] words_q,
  input wire logic carry_q,
  input wire logic carry_we_q,
  input wire logic reg_rd_en_q,
  input wire logic [4:0] reg_rd_idx_q,
  input wire logic reg_wr_en_q,
  input wire logic [4:0] reg_wr_idx_q,
  input wire logic mem_wr_en_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  bitfield_pkg::cmd_t c_q;
  // Take decode; c_q keeps the command in flight
  wire take = start && ready_q;
  wire rg = cmd.mode == bitfield_pkg::mode_register;
  wire hw = rg && cmd.reg_idx == HW_STACK_CODE;
  wire lng = cmd.mode inside {bitfield_pkg::mode_pointer_offset, bitfield_pkg::mode_stack_relative,
    bitfield_pkg::mode_long_absolute};
  wire tst = c_q.op inside {bitfield_pkg::test_masked_bits_high, bitfield_pkg::test_masked_bits_low};
  wire rg_q = c_q.mode == bitfield_pkg::mode_register;
  // No reset: only read after a take
  always_ff @(posedge clk) begin
    if (take) begin
      c_q <= cmd;
    end
  end
  property p_short;
    take && !lng && !hw |-> ##1 !done_q [*3] ##1 done_q;
  endproperty
  a_short: assert property (p_short) else $error("short form timing");
  property p_long;
    take && lng |-> ##1 !done_q [*5] ##1 done_q;
  endproperty
  a_long: assert property (p_long) else $error("long form timing");
  property p_refuse;
    take && hw |-> ##1 done_q && refused_q && !reg_rd_en_q;
  endproperty
  a_refuse: assert property (p_refuse) else $error("stack operand taken");
  property p_rd_idx;
    take && rg && !hw |-> ##1 reg_rd_en_q && reg_rd_idx_q == $past(cmd.reg_idx);
  endproperty
  a_rd_idx: assert property (p_rd_idx) else $error("wrong read index");
  property p_wr_idx;
    reg_wr_en_q |-> reg_wr_idx_q == c_q.reg_idx && done_q;
  endproperty
  a_wr_idx: assert property (p_wr_idx) else $error("write-back elsewhere");
  property p_test_nowr;
    done_q && tst |-> !reg_wr_en_q && !mem_wr_en_q;
  endproperty
  a_test_nowr: assert property (p_test_nowr) else $error("test op wrote");
  property p_mod_wr;
    done_q && !refused_q && !tst |-> reg_wr_en_q == rg_q && mem_wr_en_q == !rg_q;
  endproperty
  a_mod_wr: assert property (p_mod_wr) else $error("missing write-back");
  property p_words;
    done_q && !refused_q |-> words_q == (c_q.mode == bitfield_pkg::mode_long_absolute ? 2'h3 : 2'h2);
  endproperty
  a_words: assert property (p_words) else $error("wrong word count");
  // Carry strobe only with a completed, accepted command
  property p_carry_we;
    carry_we_q == (done_q && !refused_q);
  endproperty
  a_carry_we: assert property (p_carry_we) else $error("carry strobe off");
  // A turned-away command leaves carry alone
  property p_refuse_carry;
    refused_q |-> $stable(carry_q);
  endproperty
  a_refuse_carry: assert property (p_refuse_carry) else $error("refused op moved carry");
endmodule : bitfield_checker
bind bitfield_test_modify_unit bitfield_checker #(.HW_STACK_CODE(HW_STACK_CODE)) i_bitfield_checker (
  .clk, .reset, .start, .cmd, .ready_q, .done_q, .refused_q, .words_q, .carry_q, .carry_we_q, .reg_rd_en_q, .reg_rd_idx_q,
  .reg_wr_en_q, .reg_wr_idx_q, .mem_wr_en_q);

// file: verif/bitfield_partner.sv
/* Register file and data memory beside the unit.
 * Answers a read one cycle after its request, same clock. */
`timescale 1ns/100ps
module bitfield_partner (
  // Clock
  input wire logic clk,
  // Register file port
  input wire logic reg_rd_en_q,
  input wire logic [4:0] reg_rd_idx_q,
  output logic [15:0] reg_rd_data,
  input wire logic reg_wr_en_q,
  input wire logic [4:0] reg_wr_idx_q,
  input wire logic [15:0] reg_wr_data_q,
  // Memory port
  input wire logic mem_rd_en_q,
  input wire logic mem_wr_en_q,
  input wire logic [15:0] mem_addr_q,
  output logic [15:0] mem_rd_data,
  input wire logic [15:0] mem_wr_data_q
);
  logic [15:0] rf [32];
  logic [15:0] mem [65536];
  initial begin
    reg_rd_data = 16'h0000;
    mem_rd_data = 16'h0000;
  end
  // Read data flips outside its valid cycle, so stale use shows
  always @(posedge clk) begin
    reg_rd_data <= reg_rd_en_q ? rf[reg_rd_idx_q] : ~reg_rd_data;
    mem_rd_data <= mem_rd_en_q ? mem[mem_addr_q] : ~mem_rd_data;
    if (reg_wr_en_q) rf[reg_wr_idx_q] <= reg_wr_data_q;
    if (mem_wr_en_q) mem[mem_addr_q] <= mem_wr_data_q;
  end
endmodule : bitfield_partner

// file: verif/bitfield_test_modify_unit_test.sv
/* Bench of the bit-field unit: all ops on registers and memory.
 * Assumes the partner holds register file and memory. */
`timescale 1ns/100ps
`include "bitfield_defines.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED at %0t: got %0h want %0h", $time, (a), (b)); end end
module bitfield_test_modify_unit_test;
  logic clk, reset, start, ready_q, done_q, refused_q, carry_q, carry_we_q;
  logic reg_rd_en_q, reg_wr_en_q, mem_rd_en_q, mem_wr_en_q;
  bitfield_pkg::cmd_t cmd;
  logic [15:0] pointer_register_two, stack_pointer, reg_rd_data, mem_rd_data;
  logic [15:0] reg_wr_data_q, mem_addr_q, mem_wr_data_q;
  logic [4:0] reg_rd_idx_q, reg_wr_idx_q;
  logic [1:0] words_q;
  int fails, checked, cyc;
  bitfield_test_modify_unit i_bitfield_test_modify_unit (.clk, .reset, .start, .cmd, .ready_q, .done_q,
    .refused_q, .words_q, .carry_q, .carry_we_q, .pointer_register_two, .stack_pointer, .reg_rd_en_q,
    .reg_rd_idx_q, .reg_rd_data, .reg_wr_en_q, .reg_wr_idx_q, .reg_wr_data_q, .mem_rd_en_q, .mem_wr_en_q,
    .mem_addr_q, .mem_rd_data, .mem_wr_data_q);
  bitfield_partner i_bitfield_partner (.clk, .reg_rd_en_q, .reg_rd_idx_q, .reg_rd_data, .reg_wr_en_q,
    .reg_wr_idx_q, .reg_wr_data_q, .mem_rd_en_q, .mem_wr_en_q, .mem_addr_q, .mem_rd_data, .mem_wr_data_q);
  task automatic conclude;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  // One command: preload, issue, time it, judge carry and stored word
  task automatic run(input bitfield_pkg::op_t op, input bitfield_pkg::mode_t md, input logic [4:0] idx,
      input logic [5:0] f, input logic [15:0] v, input logic [15:0] m);
    logic [15:0] a, e, w;
    logic cy, c0, hw, lg;
    int n;
    a = md == bitfield_pkg::mode_pointer_offset ? pointer_register_two + {10'h000, f} :
      md == bitfield_pkg::mode_stack_relative ? stack_pointer - {10'h000, f} :
      md == bitfield_pkg::mode_short_absolute ? {10'h000, f} :
      md == bitfield_pkg::mode_short_io ? `BF_IO_BASE | {10'h000, f} : 16'h3456;
    hw = md == bitfield_pkg::mode_register && idx == `BF_HW_STACK_CODE;
    lg = md inside {bitfield_pkg::mode_pointer_offset, bitfield_pkg::mode_stack_relative,
      bitfield_pkg::mode_long_absolute};
    cy = op inside {bitfield_pkg::test_masked_bits_low, bitfield_pkg::raise_masked_bits} ?
      (v & m) == 16'h0000 : (v & m) == m;
    e = hw ? v : op == bitfield_pkg::invert_masked_bits ? v ^ m :
      op == bitfield_pkg::zero_masked_bits ? v & ~m : op == bitfield_pkg::raise_masked_bits ? v | m : v;
    if (md == bitfield_pkg::mode_register) i_bitfield_partner.rf[idx] = v;
    else i_bitfield_partner.mem[a] = v;
    c0 = carry_q;
    @(posedge clk);
    start <= 1'b1;
    cmd <= '{op, md, m, idx, f, 16'h3456};
    n = 0;
    do begin @(posedge clk); n++; end while (ready_q !== 1'b1 && n < 20);
    start <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (done_q !== 1'b1 && n < 20);
    `CHK(n, hw ? 1 : lg ? 6 : 4);
    `CHK(refused_q, hw);
    `CHK(carry_q, hw ? c0 : cy);
    #1;
    w = md == bitfield_pkg::mode_register ? i_bitfield_partner.rf[idx] : i_bitfield_partner.mem[a];
    `CHK(w, e);
  endtask : run
  // Every op on a register: masks all-one, all-zero, mixed, empty
  task automatic t_reg_ops;
    logic [15:0] ms [4] = '{16'h00F0, 16'h0F00, 16'h0FF0, 16'h0000};
    for (int k = 0; k < 20; k++) run(bitfield_pkg::op_t'(k % 5), bitfield_pkg::mode_register, 5'(k % 8),
      6'h00, 16'hF0F0, ms[k / 5]);
    $display("test reg_ops done");
  endtask : t_reg_ops
  // Every op in every memory form, offset at its largest
  task automatic t_mem_modes;
    for (int k = 0; k < 25; k++) run(bitfield_pkg::op_t'(k % 5), bitfield_pkg::mode_t'(k / 5 + 1), 5'h00,
      6'h3F, k % 2 ? 16'hFF34 : 16'h1234, 16'hFF00);
    $display("test mem_modes done");
  endtask : t_mem_modes
  // Stack register as operand is turned away, carry kept
  task automatic t_refuse;
    run(bitfield_pkg::invert_masked_bits, bitfield_pkg::mode_register, `BF_HW_STACK_CODE, 6'h00, 16'hAAAA,
      16'h00FF);
    $display("test refuse done");
  endtask : t_refuse
  // Second command taken in the closing cycle of the first, start held high
  task automatic t_back_to_back;
    int n;
    i_bitfield_partner.rf[1] = 16'h00F0;
    i_bitfield_partner.rf[2] = 16'h0001;
    @(posedge clk);
    start <= 1'b1;
    cmd <= '{bitfield_pkg::test_masked_bits_high, bitfield_pkg::mode_register, 16'h00F0, 5'h01, 6'h00, 16'h0000};
    n = 0;
    do begin @(posedge clk); n++; end while (ready_q !== 1'b1 && n < 20);
    cmd <= '{bitfield_pkg::raise_masked_bits, bitfield_pkg::mode_register, 16'h000F, 5'h02, 6'h00, 16'h0000};
    n = 0;
    do begin @(posedge clk); n++; end while (ready_q !== 1'b1 && n < 20);
    `CHK(n, 4);
    `CHK(done_q, 1'b1);
    `CHK(carry_q, 1'b1);
    start <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (done_q !== 1'b1 && n < 20);
    `CHK(n, 4);
    `CHK(carry_q, 1'b0);
    #1;
    `CHK(i_bitfield_partner.rf[2], 16'h000F);
    `CHK(i_bitfield_partner.rf[1], 16'h00F0);
    $display("test back_to_back done");
  endtask : t_back_to_back
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Ceiling far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    reset = 1'b1;
    start = 1'b0;
    cmd = '0;
    pointer_register_two = 16'h1230;
    stack_pointer = 16'h2040;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_reg_ops();
    t_mem_modes();
    t_refuse();
    t_back_to_back();
    conclude();
  end
endmodule : bitfield_test_modify_unit_test
